// *** src/scpio_consts.svh ***
`ifndef SCPIO_CONSTS_SVH
`define SCPIO_CONSTS_SVH

`define SCPIO_DATA_W        8
`define SCPIO_PORT_W        8
`define SCPIO_REG_CNT       16
`define SCPIO_REG_IDX_W     4
`define SCPIO_DATA_RST      8'h00
`define SCPIO_PORT_RST      8'h00
`define SCPIO_REG_RST       8'h00

`endif

// *** src/scpio_pkg.sv ***
`include "scpio_consts.svh"

package scpio_pkg;

	typedef logic [`SCPIO_DATA_W-1:0]    scpio_byte_t;
	typedef logic [`SCPIO_PORT_W-1:0]    scpio_port_t;
	typedef logic [`SCPIO_REG_IDX_W-1:0] scpio_ridx_t;

	typedef enum logic [1:0]
	{
		SCPIO_OP_NONE,
		SCPIO_OP_READ,
		SCPIO_OP_WRITE
	} scpio_op_t;

	typedef enum logic [1:0]
	{
		SCPIO_IDLE,
		SCPIO_WR,
		SCPIO_RD_WAIT,
		SCPIO_RD_CAP
	} scpio_state_t;

	typedef struct packed
	{
		scpio_state_t state;
		scpio_port_t  port_select;
		scpio_byte_t  out_data;
		logic         write_pulse;
		logic         read_pulse;
		scpio_ridx_t  rd_dest;
		logic         done;
		scpio_byte_t [`SCPIO_REG_CNT-1:0] gpr;
	} scpio_state_reg_t;

endpackage

// *** src/scpio_port_ctrl.sv ***
`timescale 1ns/10ps
// Summary of operation
// - on port write, drive select and data, pulse write for one cycle
// - up to 256 output port addresses through the full 8-bit select
// - read 8-bit values from 256 inputs, port by constant or register
// - always drive all eight write data bits
// - read pulse high on the cycle the port read is executed
// - read loads one of sixteen registers, write sends a register
`include "scpio_consts.svh"
module scpio_port_ctrl
(
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire scpio_pkg::scpio_op_t   op,
	input  wire logic               use_reg_port,
	input  wire scpio_pkg::scpio_port_t port_const,
	input  wire scpio_pkg::scpio_ridx_t port_reg,
	input  wire scpio_pkg::scpio_ridx_t data_reg,
	input  wire scpio_pkg::scpio_byte_t read_data,
	output logic                    busy,
	output logic                    done,
	output scpio_pkg::scpio_port_t  port_select,
	output scpio_pkg::scpio_byte_t  write_data,
	output logic                    write_pulse,
	output logic                    read_pulse,
	input  wire scpio_pkg::scpio_ridx_t peek_reg,
	output scpio_pkg::scpio_byte_t  peek_data
);
	import scpio_pkg::*;

	scpio_state_reg_t s_q;
	scpio_state_reg_t s_d;

	// requests are only taken while the sequencer is idle
	logic                      idle;
	logic                      start_wr;
	logic                      start_rd;

	// register file views for port number and write data
	scpio_byte_t               port_reg_val;
	scpio_byte_t               data_reg_val;
	scpio_port_t               port_pick;

	// one load strobe per register of the file
	logic [`SCPIO_REG_CNT-1:0] rd_load;

	// state compare shared by the strobes and the busy flag
	function automatic logic in_state
	(
		input scpio_state_t cur,
		input scpio_state_t want
	);
		in_state = (cur == want);
	endfunction

	// request decode shared by the write and read starts
	function automatic logic op_hit
	(
		input scpio_op_t cur,
		input scpio_op_t want
	);
		op_hit = (cur == want);
	endfunction

	// one register out of the file, used for port, data and peek
	function automatic scpio_byte_t read_reg
	(
		input scpio_byte_t [`SCPIO_REG_CNT-1:0] file,
		input scpio_ridx_t                      idx
	);
		read_reg = file[idx];
	endfunction

	// true when a register index selects register n
	function automatic logic reg_hit
	(
		input scpio_ridx_t idx,
		input int          n
	);
		reg_hit = (idx == scpio_ridx_t'(n));
	endfunction

	// port number from immediate or from a register
	function automatic scpio_port_t pick_port
	(
		input logic        use_reg,
		input scpio_port_t k,
		input scpio_byte_t r
	);
		pick_port = use_reg ? r : k;
	endfunction

	assign idle         = in_state(s_q.state, SCPIO_IDLE);
	assign start_wr     = idle && op_hit(op, SCPIO_OP_WRITE);
	assign start_rd     = idle && op_hit(op, SCPIO_OP_READ);
	assign port_reg_val = read_reg(s_q.gpr, port_reg);
	assign data_reg_val = read_reg(s_q.gpr, data_reg);

	// whole register value is the port number, no bits are masked
	assign port_pick = pick_port(use_reg_port, port_const, port_reg_val);

	// only the read destination takes the bus value
	genvar g;
	generate
		for (g = 0; g < `SCPIO_REG_CNT; g = g + 1)
		begin : g_load
			assign rd_load[g] = in_state(s_q.state, SCPIO_RD_CAP) &&
				reg_hit(s_q.rd_dest, g);
		end
	endgenerate

	always_comb
	begin
		s_d = s_q;
		s_d.write_pulse = 1'b0;
		s_d.read_pulse  = 1'b0;
		s_d.done        = 1'b0;
		unique case (s_q.state)
			SCPIO_IDLE:
			begin
				if (start_wr)
				begin
					s_d.port_select = port_pick;
					s_d.out_data    = data_reg_val;
					s_d.write_pulse = 1'b1;
					s_d.state       = SCPIO_WR;
				end
				else if (start_rd)
				begin
					// select is set one cycle ahead of the registered mux
					s_d.port_select = port_pick;
					s_d.rd_dest     = data_reg;
					s_d.state       = SCPIO_RD_WAIT;
				end
			end
			SCPIO_WR:
			begin
				// select and data stay put through the pulse cycle
				s_d.state = SCPIO_IDLE;
				s_d.done  = 1'b1;
			end
			SCPIO_RD_WAIT:
			begin
				// one cycle for the peripheral's registered mux to settle
				s_d.read_pulse = 1'b1;
				s_d.state      = SCPIO_RD_CAP;
			end
			SCPIO_RD_CAP:
			begin
				// bus value taken at the edge after the pulse cycle
				for (int k = 0; k < `SCPIO_REG_CNT; k++)
				begin
					if (rd_load[k])
					begin
						s_d.gpr[k] = read_data;
					end
				end
				s_d.done  = 1'b1;
				s_d.state = SCPIO_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_q.state       <= SCPIO_IDLE;
			s_q.port_select <= `SCPIO_PORT_RST;
			s_q.out_data    <= `SCPIO_DATA_RST;
			s_q.write_pulse <= 1'b0;
			s_q.read_pulse  <= 1'b0;
			s_q.rd_dest     <= '0;
			s_q.done        <= 1'b0;
			s_q.gpr         <= {`SCPIO_REG_CNT{`SCPIO_REG_RST}};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// busy drops in the done cycle so a new op may follow at once
	assign busy        = !idle;
	assign done        = s_q.done;
	assign write_pulse = s_q.write_pulse;
	assign read_pulse  = s_q.read_pulse;
	assign peek_data   = read_reg(s_q.gpr, peek_reg);

	// all select and data bits are driven on every write
	genvar b;
	generate
		for (b = 0; b < `SCPIO_DATA_W; b = b + 1)
		begin : g_bits
			assign port_select[b] = s_q.port_select[b];
			assign write_data[b]  = s_q.out_data[b];
		end
	endgenerate

endmodule

// *** test/scpio_chk.sv ***
`timescale 1ns/10ps
module scpio_chk
(
	input logic                   mclk,
	input logic                   sys_rst,
	input scpio_pkg::scpio_op_t   op,
	input logic                   busy,
	input logic                   done,
	input logic                   write_pulse,
	input logic                   read_pulse,
	input scpio_pkg::scpio_port_t port_select,
	input scpio_pkg::scpio_byte_t write_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire w = !busy && op == scpio_pkg::SCPIO_OP_WRITE;
	wire r = !busy && op == scpio_pkg::SCPIO_OP_READ;
	property p_wr; w |=> write_pulse ##1 !write_pulse; endproperty
	a_wr: assert property (p_wr) else $error("wr");
	property p_rd; r |=> !read_pulse ##1 read_pulse ##1 !read_pulse; endproperty
	a_rd: assert property (p_rd) else $error("rd");
	property p_hold;
		write_pulse |=> $stable(port_select) && $stable(write_data);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_excl; !(write_pulse && read_pulse); endproperty
	a_excl: assert property (p_excl) else $error("excl");
	property p_wr_done; w |=> ##1 done && !busy; endproperty
	a_wr_done: assert property (p_wr_done) else $error("wr done");
	property p_rd_done; r |=> ##2 done && !busy; endproperty
	a_rd_done: assert property (p_rd_done) else $error("rd done");
endmodule
bind scpio_port_ctrl scpio_chk u_chk(.mclk, .sys_rst, .op, .busy, .done,
	.write_pulse, .read_pulse, .port_select, .write_data);

// *** test/scpio_far.sv ***
`timescale 1ns/10ps
module scpio_far
(
	input logic                    mclk,
	input logic                    sys_rst,
	input scpio_pkg::scpio_port_t  port_select,
	input scpio_pkg::scpio_byte_t  write_data,
	input logic                    write_pulse,
	input logic                    read_pulse,
	input scpio_pkg::scpio_byte_t  sw,
	output scpio_pkg::scpio_byte_t read_data,
	output scpio_pkg::scpio_byte_t led,
	output logic [4:0]             dir,
	output scpio_pkg::scpio_byte_t pops
);
	// one select bit per port keeps decode small; the rest don't care
	always_ff @(posedge mclk)
		read_data <= port_select[0] ? {3'h0, sw[4:0]} : sw;
	always_ff @(posedge mclk)
		if (sys_rst)
		begin
			led  <= 8'h00;
			dir  <= 5'h00;
			pops <= 8'h00;
		end
		else
		begin
			if (write_pulse && port_select[0])
				led <= write_data;
			if (write_pulse && port_select[1])
				dir <= write_data[4:0];
			if (read_pulse)
				pops <= pops + 8'h01;
		end
endmodule

// *** test/soft_cpu_io_port_interface_tb_top.sv ***
`timescale 1ns/10ps
module soft_cpu_io_port_interface_tb_top;
	import scpio_pkg::*;
	logic mclk = 0, sys_rst = 1, write_pulse, read_pulse, u;
	logic use_reg_port = 0;
	scpio_op_t op = SCPIO_OP_NONE;
	scpio_port_t port_const = 8'h00, port_select, p;
	scpio_byte_t sw = 8'h00, read_data, write_data, led, pops, peek_data;
	scpio_byte_t v, exp_led = 8'h00;
	logic [4:0] dir, exp_dir = 5'h00;
	int n_mismatch = 0, n_compared = 0, seed = 27920, i;
	scpio_port_ctrl dut(.*, .port_reg(i[3:0]), .data_reg(i[3:0]),
		.peek_reg(i[3:0]), .busy(), .done());
	scpio_far far(.*);
	function automatic scpio_byte_t exp_in(input logic btn, scpio_byte_t s);
		return btn ? {3'h0, s[4:0]} : s;
	endfunction
	initial forever #5 mclk = ~mclk;
	task conclude;
		$display("compared %0d failed %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input scpio_byte_t e, s);
		n_compared++;
		n_mismatch += int'(e !== s);
		if (e !== s)
			$display("mismatch %s exp %h got %h", nm, e, s);
	endtask
	// next op is set one cycle after the cycle done is high
	task run(input scpio_op_t o, input scpio_port_t k, input logic r);
		{op, port_const, use_reg_port} = {o, k, r};
		@(posedge mclk) #1;
		op = SCPIO_OP_NONE;
		repeat (o == SCPIO_OP_READ ? 3 : 2) @(posedge mclk) #1;
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		#1 sys_rst = 0;
		for (i = 0; i < 40; i++)
		begin
			sw = i ? 8'($random(seed)) : 8'hFF;
			run(SCPIO_OP_READ, 8'(i % 2), 1'b0);
			v = exp_in(i[0], sw);
			chk("gpr", v, peek_data);
			chk("pops", 8'(i + 1), pops);
			u = (i % 4 == 3);
			p = u ? v : (i[0] ? 8'h02 : 8'h01);
			run(SCPIO_OP_WRITE, u ? ~v : p, u);
			if (p[0])
				exp_led = v;
			if (p[1])
				exp_dir = v[4:0];
			chk("sel", p, port_select);
			chk("led", exp_led, led);
			chk("dir", {3'h0, exp_dir}, {3'h0, dir});
		end
		conclude;
	end
endmodule
